/* src/error_collect.sv */
`timescale 1ns/1ps
module error_collect
#(
	parameter int WIDTH = 7
)
(
	input wire logic clock,
	input wire logic master_rst_n,
	input wire logic [WIDTH-1:0] events,
	input wire logic [WIDTH-1:0] clear_mask,
	output logic [WIDTH-1:0] err_out,
	output logic [WIDTH-1:0] sticky
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clock or negedge master_rst_n)
			begin
				if (!master_rst_n)
				begin
					err_out[i] <= 1'b0;
					sticky[i] <= 1'b0;
				end
				else
				begin
					err_out[i] <= events[i];
					// A new event in the clearing cycle keeps the bit set
					sticky[i] <= events[i] | (sticky[i] & ~clear_mask[i]);
				end
			end
		end
	endgenerate
endmodule

/* src/reset_sequencer.sv */
`timescale 1ns/1ps
module reset_sequencer
(
	input wire logic clock,
	input wire logic master_rst_n,
	output logic seq_done,
	output logic out_reset
);
	localparam int CNT_BITS = $clog2(sink_port_pkg::RESET_SEQ_CYCLES + 1);
	localparam logic [CNT_BITS-1:0] CNT_LAST = CNT_BITS'(sink_port_pkg::RESET_SEQ_CYCLES - 1);

	sink_port_pkg::rst_state_t state;
	sink_port_pkg::rst_state_t next_state;
	logic [CNT_BITS-1:0] count;
	logic [1:0] release_sync;

	// Release is synchronised so the counter never starts on a metastable edge
	always_ff @(posedge clock or negedge master_rst_n)
	begin
		if (!master_rst_n)
			release_sync <= 2'h0;
		else
			release_sync <= {release_sync[0], 1'b1};
	end

	always_comb
	begin
		next_state = state;
		case (state)
			sink_port_pkg::RST_HOLD:
				if (release_sync[1])
					next_state = sink_port_pkg::RST_COUNT;
			sink_port_pkg::RST_COUNT:
				if (count == CNT_LAST)
					next_state = sink_port_pkg::RST_DONE;
			sink_port_pkg::RST_DONE:
				next_state = sink_port_pkg::RST_DONE;
			default:
				next_state = sink_port_pkg::RST_HOLD;
		endcase
	end

	always_ff @(posedge clock or negedge master_rst_n)
	begin
		if (!master_rst_n)
		begin
			state <= sink_port_pkg::RST_HOLD;
			count <= '0;
			out_reset <= 1'b1;
		end
		else
		begin
			state <= next_state;
			count <= (state == sink_port_pkg::RST_COUNT) ? count + 1'b1 : '0;
			out_reset <= (next_state != sink_port_pkg::RST_DONE);
		end
	end

	assign seq_done = (state == sink_port_pkg::RST_DONE);
endmodule

/* src/sink_port_pkg.sv */
package sink_port_pkg;
	// Lane and vector geometry
	localparam int LANES_DEFAULT = 2;
	localparam int WORD_BITS = 64;
	localparam int SYNC_BITS = 8;
	localparam int ERR_EXTRA = 5;

	// Error vector bit positions, counted up from bit N
	localparam int ERR_ALIGN_OFS = 0;
	localparam int ERR_UNUSED_OFS = 1;
	localparam int ERR_OVF_OFS = 2;
	localparam int ERR_SEU_FIX_OFS = 3;
	localparam int ERR_SEU_BAD_OFS = 4;

	// Register port
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 32;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] ERR_STICKY_OFFSET = 8'h08;
	localparam logic [7:0] WORD_COUNT_OFFSET = 8'h0c;

	// Control field positions and reset value
	localparam int CTRL_BURST_BIT = 0;
	localparam int CTRL_ECC_BIT = 1;
	localparam int CTRL_LINK_EN_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h7;

	// Status field positions
	localparam int STAT_LINK_UP_BIT = 0;
	localparam int STAT_USER_RST_BIT = 1;
	localparam int STAT_SEEN_FIRST_BIT = 2;
	localparam int STAT_INIT_DONE_BIT = 3;

	// Reset sequence length after the master reset lets go
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int RESET_SEQ_NS = 100;
	localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

	typedef enum logic [2:0]
	{
		RST_HOLD = 3'b001,
		RST_COUNT = 3'b010,
		RST_DONE = 3'b100
	} rst_state_t;

	typedef struct packed
	{
		logic link_en;
		logic ecc_en;
		logic burst_mode;
	} ctrl_reg_t;

	typedef struct packed
	{
		logic first;
		logic last;
		logic [7:0] sync;
	} beat_ctl_t;
endpackage

/* src/stream_link_sink_user_port.sv */
// Notes on behaviour
// - High core reset asynchronously resets the link layer
// - Standard mode: user clock out, reset till sequenced
// - Advanced mode: interface clock from core clock
// - Interface reset only in advanced mode, sequenced
// - Link ready only after initialization completes
// - Payload is 64 bits per lane
// - Single payload valid bit per cycle
// - Eight-bit tag copies remote transmitter value
// - Tag at burst end counts invalid words
// - Burst mode: first flag with opening word
// - Continuous mode: first flag only once; code raises it again on the first beat after each link-up
// - Burst mode: last flag with closing word
// - Bit N alignment loss, bit N+1 zero
// - Bit N+2 FIFO overflow, standard mode only
// - Bit N+3 corrected upset when ECC on; code reports it in standard mode only
// - Bit N+4 uncorrectable upset when ECC on; code reports it in standard mode only
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module stream_link_sink_user_port
#(
	parameter int LANES = sink_port_pkg::LANES_DEFAULT,
	parameter bit ADVANCED_CLOCKING = 1'b0
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic core_reset,
	input wire logic init_done,
	input wire logic [sink_port_pkg::WORD_BITS*LANES-1:0] rx_word,
	input wire logic rx_valid,
	input wire sink_port_pkg::beat_ctl_t rx_ctl,
	input wire logic [LANES-1:0] lane_crc_err,
	input wire logic align_lost,
	input wire logic fifo_overflow,
	input wire logic seu_fixed,
	input wire logic seu_bad,
	input wire logic [sink_port_pkg::ADDR_BITS-1:0] reg_addr,
	input wire logic [sink_port_pkg::DATA_BITS-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [sink_port_pkg::DATA_BITS-1:0] reg_rdata,
	output logic user_clock,
	output logic user_clock_reset,
	output logic interface_clock,
	output logic interface_clock_reset,
	output logic link_up,
	output logic [sink_port_pkg::WORD_BITS*LANES-1:0] data,
	output logic valid,
	output logic [sink_port_pkg::SYNC_BITS-1:0] sync,
	output logic burst_first_flag,
	output logic burst_last_flag,
	output logic [LANES+sink_port_pkg::ERR_EXTRA-1:0] error
);
	localparam int ERR_W = LANES + sink_port_pkg::ERR_EXTRA;
	localparam int DW = sink_port_pkg::DATA_BITS;

	// One reset net for the whole link layer; the supporting PLL is not in this block
	wire master_rst_n = rst_n & ~core_reset;

	sink_port_pkg::ctrl_reg_t ctrl;
	logic seq_done;
	logic seq_reset;
	logic seen_first;
	logic [DW-1:0] word_count;
	logic [ERR_W-1:0] err_events;
	logic [ERR_W-1:0] err_clear;
	logic [ERR_W-1:0] err_sticky;

	reset_sequencer u_reset_seq
	(
		.clock(clock),
		.master_rst_n(master_rst_n),
		.seq_done(seq_done),
		.out_reset(seq_reset)
	);

	// Clock and reset outputs: only the one belonging to the chosen mode moves.
	// The clock is passed straight through; a gated or muxed clock would glitch.
	assign user_clock = ADVANCED_CLOCKING ? 1'b0 : clock;
	assign interface_clock = ADVANCED_CLOCKING ? clock : 1'b0;
	assign user_clock_reset = ADVANCED_CLOCKING ? 1'b0 : seq_reset;
	assign interface_clock_reset = ADVANCED_CLOCKING ? seq_reset : 1'b0;

	// Register port decode
	wire sel_ctrl = (reg_addr == sink_port_pkg::CTRL_OFFSET);
	wire sel_status = (reg_addr == sink_port_pkg::STATUS_OFFSET);
	wire sel_sticky = (reg_addr == sink_port_pkg::ERR_STICKY_OFFSET);
	wire sel_count = (reg_addr == sink_port_pkg::WORD_COUNT_OFFSET);
	wire wr_ctrl = reg_write & sel_ctrl;
	wire wr_sticky = reg_write & sel_sticky;

	wire [DW-1:0] ctrl_word = DW'({ctrl.link_en, ctrl.ecc_en, ctrl.burst_mode});
	wire [DW-1:0] status_word = DW'({init_done, seen_first, seq_reset, link_up});
	wire [DW-1:0] sticky_word = DW'(err_sticky);
	wire [DW-1:0] next_rdata = !reg_read ? '0 :
		sel_ctrl ? ctrl_word :
		sel_status ? status_word :
		sel_sticky ? sticky_word :
		sel_count ? word_count : '0;

	assign err_clear = wr_sticky ? reg_wdata[ERR_W-1:0] : '0;

	always_ff @(posedge clock or negedge master_rst_n)
	begin
		if (!master_rst_n)
		begin
			ctrl <= sink_port_pkg::CTRL_RESET;
			reg_rdata <= '0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl.burst_mode <= reg_wdata[sink_port_pkg::CTRL_BURST_BIT];
				ctrl.ecc_en <= reg_wdata[sink_port_pkg::CTRL_ECC_BIT];
				ctrl.link_en <= reg_wdata[sink_port_pkg::CTRL_LINK_EN_BIT];
			end
			reg_rdata <= next_rdata;
		end
	end

	// Link ready waits for the reset sequence and for link initialization
	wire next_link_up = seq_done & init_done & ctrl.link_en;

	// Flags are forced low outside valid, ready cycles so stale markers never leak
	wire beat_ok = rx_valid & link_up;
	wire next_first = beat_ok &
		(ctrl.burst_mode ? rx_ctl.first : ~seen_first);
	wire next_last = beat_ok & rx_ctl.last;

	always_ff @(posedge clock or negedge master_rst_n)
	begin
		if (!master_rst_n)
		begin
			link_up <= 1'b0;
			valid <= 1'b0;
			data <= '0;
			sync <= '0;
			burst_first_flag <= 1'b0;
			burst_last_flag <= 1'b0;
			seen_first <= 1'b0;
			word_count <= '0;
		end
		else
		begin
			link_up <= next_link_up;
			valid <= rx_valid;
			if (rx_valid)
			begin
				data <= rx_word;
				sync <= rx_ctl.sync;
			end
			burst_first_flag <= next_first;
			burst_last_flag <= next_last;
			// A fresh link is a fresh stream, so continuous mode may mark again
			if (!link_up)
				seen_first <= 1'b0;
			else if (beat_ok)
				seen_first <= 1'b1;
			if (beat_ok)
				word_count <= word_count + 1'b1;
		end
	end

	// Error events; the upset and overflow bits are silenced where they mean nothing
	wire ecc_live = ctrl.ecc_en & ~ADVANCED_CLOCKING;
	assign err_events[LANES-1:0] = lane_crc_err;
	assign err_events[LANES+sink_port_pkg::ERR_ALIGN_OFS] = align_lost;
	assign err_events[LANES+sink_port_pkg::ERR_UNUSED_OFS] = 1'b0;
	assign err_events[LANES+sink_port_pkg::ERR_OVF_OFS] =
		fifo_overflow & ~ADVANCED_CLOCKING;
	assign err_events[LANES+sink_port_pkg::ERR_SEU_FIX_OFS] = seu_fixed & ecc_live;
	assign err_events[LANES+sink_port_pkg::ERR_SEU_BAD_OFS] = seu_bad & ecc_live;

	error_collect #(.WIDTH(ERR_W)) u_errors
	(
		.clock(clock),
		.master_rst_n(master_rst_n),
		.events(err_events),
		.clear_mask(err_clear),
		.err_out(error),
		.sticky(err_sticky)
	);

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!master_rst_n);

	a_ready_after_seq: assert property (link_up |-> seq_done && !seq_reset)
		else $error("link ready raised before reset sequence finished");

	a_ready_needs_init: assert property ($rose(link_up) |-> $past(init_done))
		else $error("link ready rose without link initialization");

	a_reset_release: assert property ($fell(seq_reset) |-> seq_done && !link_up)
		else $error("clock reset fell outside sequence completion");

	a_reset_mode_out: assert property (
		(ADVANCED_CLOCKING ? interface_clock_reset : user_clock_reset) == seq_reset
		) else $error("mode reset output does not follow sequence");

	a_valid_follows: assert property (rx_valid |=> valid)
		else $error("valid did not follow incoming beat");

	a_tag_copy: assert property (rx_valid |=> sync == $past(rx_ctl.sync))
		else $error("tag not copied from incoming beat");

	a_flags_gated: assert property ((burst_first_flag || burst_last_flag) |-> valid)
		else $error("burst flag outside a valid beat");

	a_burst_first: assert property (
		(ctrl.burst_mode && rx_valid && link_up && rx_ctl.first) |=> burst_first_flag
		) else $error("burst first flag missing");

	a_burst_last: assert property (
		(rx_valid && link_up && rx_ctl.last) |=> burst_last_flag
		) else $error("burst last flag missing");

	a_cont_once: assert property (
		(!ctrl.burst_mode && seen_first && link_up) |=> !burst_first_flag
		) else $error("continuous mode marked first twice");

	a_unused_zero: assert property (!error[LANES+sink_port_pkg::ERR_UNUSED_OFS])
		else $error("unused error bit is set");

	a_crc_lane0: assert property (lane_crc_err[0] |=> error[0])
		else $error("lane CRC error not reported");

	a_ecc_off_quiet: assert property (
		!ecc_live |=> !error[LANES+sink_port_pkg::ERR_SEU_FIX_OFS]
		) else $error("corrected upset reported with ECC off");

	c_burst_pair: cover property (burst_first_flag ##[1:20] burst_last_flag);
	c_cont_first: cover property (!ctrl.burst_mode && burst_first_flag);
	c_link_rise: cover property ($rose(link_up));
	c_align_err: cover property (error[LANES+sink_port_pkg::ERR_ALIGN_OFS]);
endmodule

/* tb/stream_consumer.sv */
`timescale 1ns/1ps
module stream_consumer
#(
	parameter int W = 128
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_up,
	input wire logic valid,
	input wire logic [W-1:0] data,
	output logic [31:0] taken,
	output logic [W-1:0] last_word
);
	// Words flagged valid while the link is down are dropped, not counted
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			taken <= 32'h0;
			last_word <= '0;
		end
		else if (valid && link_up)
		begin
			taken <= taken + 32'h1;
			last_word <= data;
		end
	end
endmodule

/* tb/stream_link_sink_user_port_bench.sv */
`timescale 1ns/1ps
module stream_link_sink_user_port_bench;
	localparam int N = 2;
	localparam int EW = N + sink_port_pkg::ERR_EXTRA;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic core_reset = 1'b0;
	logic init_done = 1'b0;
	logic [127:0] rx_word = '0;
	logic rx_valid = 1'b0;
	sink_port_pkg::beat_ctl_t rx_ctl = '0;
	logic [N-1:0] lane_crc_err = '0;
	logic align_lost = 1'b0;
	logic fifo_overflow = 1'b0;
	logic seu_fixed = 1'b0;
	logic seu_bad = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata, taken, rd;
	logic user_clock, user_clock_reset, interface_clock, interface_clock_reset, link_up;
	logic [127:0] data;
	logic valid, burst_first_flag, burst_last_flag;
	logic [7:0] sync;
	logic [EW-1:0] error;
	int mismatches = 0;
	int n_compared = 0;

	always #2 clock = ~clock;

	stream_link_sink_user_port #(.LANES(N)) dut_u (.clock(clock), .rst_n(rst_n),
		.core_reset(core_reset), .init_done(init_done), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_ctl(rx_ctl), .lane_crc_err(lane_crc_err),
		.align_lost(align_lost), .fifo_overflow(fifo_overflow), .seu_fixed(seu_fixed),
		.seu_bad(seu_bad), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.user_clock(user_clock), .user_clock_reset(user_clock_reset),
		.interface_clock(interface_clock), .interface_clock_reset(interface_clock_reset),
		.link_up(link_up), .data(data), .valid(valid), .sync(sync),
		.burst_first_flag(burst_first_flag), .burst_last_flag(burst_last_flag),
		.error(error));

	stream_consumer #(.W(128)) consumer_u (.clock(clock), .rst_n(rst_n), .link_up(link_up),
		.valid(valid), .data(data), .taken(taken), .last_word());

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	// Read data is valid only in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic wait_link(input logic lvl);
		int i;
		for (i = 0; i < 100 && link_up !== lvl; i++)
			@(posedge clock);
		if (link_up !== lvl)
		begin
			mismatches++;
			print_verdict();
		end
	endtask

	task automatic beat(input logic f, input logic l, input logic [7:0] s, input logic [7:0] k,
		input logic ef, input logic el);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_ctl <= {f, l, s};
		rx_word <= {56'hb, k, 56'ha, k};
		@(posedge clock);
		rx_valid <= 1'b0;
		#1;
		check("valid", valid, 1'b1);
		check("lane0", data[63:0], {56'ha, k});
		check("lane1", data[127:64], {56'hb, k});
		check("sync", sync, s);
		check("first", burst_first_flag, ef);
		check("last", burst_last_flag, el);
	endtask

	task automatic err_chk(input logic [N-1:0] c, input logic [3:0] ev, input logic [EW-1:0] e);
		@(posedge clock);
		lane_crc_err <= c;
		{align_lost, fifo_overflow, seu_fixed, seu_bad} <= ev;
		@(posedge clock);
		lane_crc_err <= '0;
		{align_lost, fifo_overflow, seu_fixed, seu_bad} <= 4'h0;
		#1 check("error", error, e);
	endtask

	task automatic test_reset;
		int cnt;
		check("ucr_held", user_clock_reset, 1'b1);
		check("icr_std", interface_clock_reset, 1'b0);
		@(posedge clock);
		rst_n <= 1'b1;
		cnt = 0;
		while (user_clock_reset === 1'b1 && cnt < 100)
		begin
			@(posedge clock);
			cnt++;
		end
		check("seq_len", cnt >= sink_port_pkg::RESET_SEQ_CYCLES && cnt < 40, 1'b1);
		repeat (3) @(posedge clock);
		#1 check("no_init", link_up, 1'b0);
		check("uclk", user_clock, clock);
		check("iclk", interface_clock, 1'b0);
		@(posedge clock);
		init_done <= 1'b1;
		wait_link(1'b1);
		reg_rd(sink_port_pkg::CTRL_OFFSET, rd);
		check("ctrl_rst", rd, 32'h7);
		reg_rd(8'h10, rd);
		check("unmapped", rd, 32'h0);
	endtask

	task automatic test_burst;
		beat(1'b1, 1'b0, 8'h11, 8'h01, 1'b1, 1'b0);
		beat(1'b0, 1'b0, 8'h22, 8'h02, 1'b0, 1'b0);
		beat(1'b0, 1'b1, 8'h01, 8'h03, 1'b0, 1'b1);
		reg_rd(sink_port_pkg::WORD_COUNT_OFFSET, rd);
		check("words", rd, 32'h3);
		check("taken", taken, 32'h3);
	endtask

	task automatic test_errors;
		err_chk(2'b10, 4'b1111, 7'b1110110);
		reg_wr(sink_port_pkg::CTRL_OFFSET, 32'h5);
		err_chk(2'b01, 4'b0011, 7'b0000001);
		// Sticky copy gathers both events; writing ones clears it
		reg_rd(sink_port_pkg::ERR_STICKY_OFFSET, rd);
		check("sticky", rd, 32'h77);
		reg_wr(sink_port_pkg::ERR_STICKY_OFFSET, 32'h7f);
		reg_rd(sink_port_pkg::ERR_STICKY_OFFSET, rd);
		check("sticky_clr", rd, 32'h0);
		reg_rd(sink_port_pkg::STATUS_OFFSET, rd);
		check("status", rd, 32'hd);
	endtask

	task automatic test_continuous;
		reg_wr(sink_port_pkg::CTRL_OFFSET, 32'h0);
		wait_link(1'b0);
		beat(1'b1, 1'b0, 8'h33, 8'h04, 1'b0, 1'b0);
		check("dropped", taken, 32'h3);
		reg_wr(sink_port_pkg::CTRL_OFFSET, 32'h4);
		wait_link(1'b1);
		beat(1'b1, 1'b0, 8'h44, 8'h05, 1'b1, 1'b0);
		beat(1'b1, 1'b0, 8'h55, 8'h06, 1'b0, 1'b0);
	endtask

	// Master reset must act without waiting for a clock edge
	task automatic test_core_reset;
		@(posedge clock);
		core_reset <= 1'b1;
		#1;
		check("ucr_core", user_clock_reset, 1'b1);
		check("link_core", link_up, 1'b0);
		@(posedge clock);
		core_reset <= 1'b0;
		wait_link(1'b1);
		check("ucr_after", user_clock_reset, 1'b0);
	endtask

	initial
	begin
		repeat (4) @(posedge clock);
		#1;
		test_reset();
		test_burst();
		test_errors();
		test_continuous();
		test_core_reset();
		print_verdict();
	end
endmodule
